// ### src/adcrr_regs.vh
// Constants for the round-robin readback controller: offsets, fields,
// reset values and timing counts.
// Assumes it is included by bare name by the design, monitor and bench files.
`ifndef ADCRR_REGS_VH
`define ADCRR_REGS_VH

// Register offsets on the plain register port (8-bit address).
`define ADCRR_A_CTRL     8'h00
`define ADCRR_A_CHEN     8'h01
`define ADCRR_A_LIMDIR   8'h02
`define ADCRR_A_WARN     8'h03
`define ADCRR_A_IRQST    8'h04
`define ADCRR_A_IRQMSK   8'h05
`define ADCRR_A_RES_BASE 4'h1
`define ADCRR_A_LIM_BASE 4'h2

// Control register fields.
`define ADCRR_CTRL_RUN   0
`define ADCRR_CTRL_CONT  1
`define ADCRR_CTRL_AVG   2
`define ADCRR_CTRL_BUSY  3

// Channel map: ten supply inputs, local sensor, two remote sensors.
`define ADCRR_NCH        4'hd
`define ADCRR_LOCAL_CH   4'ha
`define ADCRR_REM0_CH    4'hb
`define ADCRR_REM1_CH    4'hc
`define ADCRR_IRQ_DONE   13

// Averaging and remote step counts (sixteen each).
`define ADCRR_LAST_LOOP  4'hf
`define ADCRR_LAST_STEP  4'hf

// Temperature code span, offset binary.
`define ADCRR_TEMP_MIN   12'h400
`define ADCRR_TEMP_MAX   12'hc00

// Reset values.
`define ADCRR_RST_CHEN   13'h0000
`define ADCRR_RST_LIMDIR 13'h1fff
`define ADCRR_RST_LIMIT  12'hfff
`define ADCRR_RST_MASK   14'h0000

// Timing: times as printed, counts derived from the 40 MHz clock.
`define ADCRR_CLK_MHZ    40
`define ADCRR_CONV_US    500
`define ADCRR_REMOTE_MS  600
`define ADCRR_REM_STEPS  16
`define ADCRR_CONV_CYC   (`ADCRR_CONV_US * `ADCRR_CLK_MHZ)
`define ADCRR_RSUB_CYC   (`ADCRR_REMOTE_MS * 1000 * `ADCRR_CLK_MHZ / `ADCRR_REM_STEPS)

`endif

// ### src/adcrr_top.v
// Round-robin scanner, result store, limit compare and interrupt logic
// for a 13-channel supervisory converter.
// Assumes the analog core converts the selected channel and presents a
// stable 12-bit code on adc_data_in by the end of each slot.
//
// Overview of operation
// - Thirteen channels, any enabled subset scanned.
// - Single pass or continuous scan loop.
// - Averaging repeats loop sixteen times, then writes.
// - Results are unsigned 12-bit codes, full 4095.
// - One limit per channel, max or min.
// - Crossing limit raises readable warning to engine.
// - Start by register write or sequencing engine.
// - Each supply and local sensor channel slot lasts 500 microseconds.
// - Temperature codes offset binary, 0x400 to 0xc00.
// - Temperature channels have own limit warnings.
// - Remote excitation alternates base and multiple current.
// - Remote result averages sixteen steps over 600 ms.
// - Two remote sensors, each own pin pair.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "adcrr_regs.vh"

module adcrr_top #(
    parameter [24:0] CONV_CYC = `ADCRR_CONV_CYC, // Supply channel slot length.
    parameter [24:0] RSUB_CYC = `ADCRR_RSUB_CYC  // One remote step length.
) (
    input  wire        clk_in,                        // System clock, 40 MHz.
    input  wire        rst_in,                        // Asynchronous reset.
    input  wire [7:0]  addr_in,                       // Register address.
    input  wire [15:0] wdata_in,                      // Register write data.
    input  wire        wr_in,                         // Write strobe.
    input  wire        rd_in,                         // Read strobe.
    output reg  [15:0] rdata_out,                     // Read data, next cycle.
    input  wire        sequencing_engine_adc_on_in,   // Engine scan request.
    input  wire [11:0] adc_data_in,                   // Converter code.
    output reg  [3:0]  ch_sel_out,                    // Input selector.
    output reg         conv_start_out,                // Conversion start pulse.
    output reg  [1:0]  diode_sel_out,                 // Remote sensor select.
    output reg         excite_high_out,               // Multiple current on.
    output reg  [12:0] sequencing_engine_warn_out,    // Live limit warnings.
    output reg         irq_out,                       // Level interrupt.
    output reg         busy_out                       // Scan in progress.
);

    // Scanner states.
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_PICK = 2'd1;
    localparam [1:0] S_CONV = 2'd2;

    // Control and configuration held by software.
    reg         run;                  // Run request bit.
    reg         cont;                 // Continuous mode.
    reg         avg;                  // Sixteen-loop averaging.
    reg  [12:0] ch_en;                // Channel enables.
    reg  [12:0] lim_dir;              // One means the limit is a maximum.
    reg  [13:0] irq_stat;             // Sticky events.
    reg  [13:0] irq_mask;             // Event mask.

    // Per-channel storage.
    reg  [11:0] result [0:12];        // Output registers.
    reg  [11:0] limit  [0:12];        // Single limit per channel.
    reg  [15:0] acc    [0:12];        // Averaging sums over loops.

    // Scanner state.
    reg  [1:0]  state;                // Current state.
    reg  [3:0]  ch;                   // Channel under work, 13 ends a loop.
    reg  [3:0]  loop_cnt;             // Averaging loop number.
    reg  [3:0]  step;                 // Remote measurement step.
    reg  [24:0] tmr;                  // Slot timer.
    reg  [15:0] racc;                 // Remote step sum.
    reg         se_q;                 // Engine request, previous cycle.
    reg  [15:0] next_rdata;           // Read mux output.
    integer     i;                    // Reset loop index.

    // True when the address falls in a per-channel window at base.
    function in_win;
        input [7:0] a;
        input [3:0] base;
        begin
            in_win = (a[7:4] == base) && (a[3:0] < `ADCRR_NCH);
        end
    endfunction

    // A maximum warns above the limit, a minimum below it.
    function crossed;
        input [11:0] v;
        input [11:0] lim;
        input        is_max;
        begin
            crossed = is_max ? (v > lim) : (v < lim);
        end
    endfunction

    // Temperature codes are held inside the offset binary span.
    function [11:0] tclamp;
        input [11:0] v;
        begin
            if (v < `ADCRR_TEMP_MIN) begin
                tclamp = `ADCRR_TEMP_MIN;
            end else if (v > `ADCRR_TEMP_MAX) begin
                tclamp = `ADCRR_TEMP_MAX;
            end else begin
                tclamp = v;
            end
        end
    endfunction

    // Slot decode for the channel under work.
    wire        is_remote = (ch == `ADCRR_REM0_CH) || (ch == `ADCRR_REM1_CH);
    wire        is_temp   = (ch >= `ADCRR_LOCAL_CH) && (ch < `ADCRR_NCH);
    wire [24:0] slot_last = (is_remote ? RSUB_CYC : CONV_CYC) - 25'd1;
    wire [24:0] half_slot = RSUB_CYC >> 1;

    // Remote sum of all sixteen steps, and the sample it yields.
    wire [15:0] rsum     = racc + {4'h0, adc_data_in};
    wire [11:0] raw      = is_remote ? rsum[15:4] : adc_data_in;
    wire [11:0] sample   = is_temp ? tclamp(raw) : raw;

    // Loop average and the value finally stored.
    wire [15:0] asum     = acc[ch] + {4'h0, sample};
    wire [11:0] value    = avg ? asum[15:4] : sample;
    wire        mid_avg  = avg && (loop_cnt != `ADCRR_LAST_LOOP);
    wire        hit      = crossed(value, limit[ch], lim_dir[ch]);

    // Bus decodes that the scanner logic also uses.
    wire wr_ctrl   = wr_in && (addr_in == `ADCRR_A_CTRL);
    wire rd_irqst  = rd_in && (addr_in == `ADCRR_A_IRQST);
    wire se_rise   = sequencing_engine_adc_on_in && !se_q;
    wire start_req = (wr_ctrl && wdata_in[`ADCRR_CTRL_RUN]) || se_rise;
    wire keep_on   = run || sequencing_engine_adc_on_in;

    // Read mux; unmapped addresses and the window gaps read as zero.
    always @* begin
        next_rdata = 16'h0000;
        if (addr_in == `ADCRR_A_CTRL) begin
            next_rdata = {12'h000, busy_out, avg, cont, run};
        end else if (addr_in == `ADCRR_A_CHEN) begin
            next_rdata = {3'h0, ch_en};
        end else if (addr_in == `ADCRR_A_LIMDIR) begin
            next_rdata = {3'h0, lim_dir};
        end else if (addr_in == `ADCRR_A_WARN) begin
            next_rdata = {3'h0, sequencing_engine_warn_out};
        end else if (addr_in == `ADCRR_A_IRQST) begin
            next_rdata = {2'h0, irq_stat};
        end else if (addr_in == `ADCRR_A_IRQMSK) begin
            next_rdata = {2'h0, irq_mask};
        end else if (in_win(addr_in, `ADCRR_A_RES_BASE)) begin
            next_rdata = {4'h0, result[addr_in[3:0]]};
        end else if (in_win(addr_in, `ADCRR_A_LIM_BASE)) begin
            next_rdata = {4'h0, limit[addr_in[3:0]]};
        end
    end

    // Read data appear only in the cycle after the strobe.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= rd_in ? next_rdata : 16'h0000;
        end
    end

    // The interrupt follows the masked sticky bits one cycle later.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat & irq_mask);
        end
    end

    // Registers and scanner share one process because the scanner
    // clears the run bit and sets sticky bits that software also touches.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run                        <= 1'b0;
            cont                       <= 1'b0;
            avg                        <= 1'b0;
            ch_en                      <= `ADCRR_RST_CHEN;
            lim_dir                    <= `ADCRR_RST_LIMDIR;
            irq_stat                   <= 14'h0000;
            irq_mask                   <= `ADCRR_RST_MASK;
            for (i = 0; i < 13; i = i + 1) begin
                result[i] <= 12'h000;
                limit[i]  <= `ADCRR_RST_LIMIT;
                acc[i]    <= 16'h0000;
            end
            state                      <= S_IDLE;
            ch                         <= 4'h0;
            loop_cnt                   <= 4'h0;
            step                       <= 4'h0;
            tmr                        <= 25'd0;
            racc                       <= 16'h0000;
            se_q                       <= 1'b0;
            ch_sel_out                 <= 4'h0;
            conv_start_out             <= 1'b0;
            diode_sel_out              <= 2'b00;
            excite_high_out            <= 1'b0;
            sequencing_engine_warn_out <= 13'h0000;
            busy_out                   <= 1'b0;
        end else begin
            se_q           <= sequencing_engine_adc_on_in;
            conv_start_out <= 1'b0;

            // A read of the status clears it; later sets in this cycle win.
            if (rd_irqst) begin
                irq_stat <= 14'h0000;
            end

            // Software writes.
            if (wr_ctrl) begin
                run  <= wdata_in[`ADCRR_CTRL_RUN];
                cont <= wdata_in[`ADCRR_CTRL_CONT];
                avg  <= wdata_in[`ADCRR_CTRL_AVG];
            end else if (wr_in && (addr_in == `ADCRR_A_CHEN)) begin
                ch_en <= wdata_in[12:0];
            end else if (wr_in && (addr_in == `ADCRR_A_LIMDIR)) begin
                lim_dir <= wdata_in[12:0];
            end else if (wr_in && (addr_in == `ADCRR_A_IRQMSK)) begin
                irq_mask <= wdata_in[13:0];
            end else if (wr_in && in_win(addr_in, `ADCRR_A_LIM_BASE)) begin
                limit[addr_in[3:0]] <= wdata_in[11:0];
            end

            case (state)
                // Waiting for a start from software or the engine.
                S_IDLE: begin
                    diode_sel_out   <= 2'b00;
                    excite_high_out <= 1'b0;
                    if (start_req) begin
                        state    <= S_PICK;
                        ch       <= 4'h0;
                        loop_cnt <= 4'h0;
                        busy_out <= 1'b1;
                    end
                end

                // Skip disabled channels, close loops and passes.
                S_PICK: begin
                    excite_high_out <= 1'b0;
                    if (ch == `ADCRR_NCH) begin
                        ch <= 4'h0;
                        if (mid_avg) begin
                            loop_cnt <= loop_cnt + 4'h1;
                        end else begin
                            loop_cnt                 <= 4'h0;
                            irq_stat[`ADCRR_IRQ_DONE] <= 1'b1;
                            if (!(cont && keep_on)) begin
                                state    <= S_IDLE;
                                run      <= 1'b0;
                                busy_out <= 1'b0;
                            end
                        end
                    end else if (ch_en[ch]) begin
                        state          <= S_CONV;
                        ch_sel_out     <= ch;
                        conv_start_out <= 1'b1;
                        tmr            <= 25'd0;
                        step           <= 4'h0;
                        racc           <= 16'h0000;
                        if (ch == `ADCRR_REM0_CH) begin
                            diode_sel_out <= 2'b01;
                        end else if (ch == `ADCRR_REM1_CH) begin
                            diode_sel_out <= 2'b10;
                        end else begin
                            diode_sel_out <= 2'b00;
                        end
                    end else begin
                        ch <= ch + 4'h1;
                    end
                end

                // Time one slot; remote channels run sixteen steps.
                S_CONV: begin
                    // Base current in the first half, multiple in the second.
                    excite_high_out <= is_remote && (tmr >= half_slot);
                    if (tmr != slot_last) begin
                        tmr <= tmr + 25'd1;
                    end else begin
                        tmr <= 25'd0;
                        if (is_remote && (step != `ADCRR_LAST_STEP)) begin
                            racc           <= rsum;
                            step           <= step + 4'h1;
                            conv_start_out <= 1'b1;
                        end else begin
                            state <= S_PICK;
                            ch    <= ch + 4'h1;
                            if (mid_avg) begin
                                acc[ch] <= asum;
                            end else begin
                                // Output registers change only here.
                                result[ch]                     <= value;
                                acc[ch]                        <= 16'h0000;
                                sequencing_engine_warn_out[ch] <= hit;
                                if (hit) begin
                                    irq_stat[ch] <= 1'b1;
                                end
                            end
                        end
                    end
                end

                default: begin
                    state    <= S_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

endmodule // adcrr_top

// ### bench/adcrr_monitor.sv
// Checker for the round-robin controller: port-level timing relations.
// Assumes it is bound to adcrr_top and sees only that module's ports.
`timescale 1ns/1ps
`include "adcrr_regs.vh"
module adcrr_monitor #(
    parameter [24:0] CONV_CYC = 25'd8, // Supply slot length in cycles.
    parameter [24:0] RSUB_CYC = 25'd8  // Remote step length in cycles.
) (
    input wire        clk_in,
    input wire        rst_in,
    input wire [7:0]  addr_in,
    input wire [15:0] wdata_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire [15:0] rdata_out,
    input wire        sequencing_engine_adc_on_in,
    input wire [11:0] adc_data_in,
    input wire [3:0]  ch_sel_out,
    input wire        conv_start_out,
    input wire [1:0]  diode_sel_out,
    input wire        excite_high_out,
    input wire [12:0] sequencing_engine_warn_out,
    input wire        irq_out,
    input wire        busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // A run request written while the scanner is idle.
    sequence s_run_wr;
        wr_in && addr_in == `ADCRR_A_CTRL && wdata_in[0] && !busy_out;
    endsequence
    // Start of one step of a remote sensor channel.
    sequence s_rem_start;
        conv_start_out && ch_sel_out >= 4'hb;
    endsequence
    a_run_busy: assert property (s_run_wr |-> ##[1:2] busy_out)
        else $error("Run write left the scanner idle.");
    a_eng_busy: assert property ($rose(sequencing_engine_adc_on_in) && !busy_out |-> ##[1:3] busy_out)
        else $error("Engine request left the scanner idle.");
    a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("Read data shown without a read.");
    a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
        else $error("Conversion start longer than one cycle.");
    a_slot_len: assert property (conv_start_out && ch_sel_out < 4'hb |=> !conv_start_out [*7])
        else $error("Supply slot ended early.");
    a_rem_diode: assert property (s_rem_start |=> diode_sel_out == (ch_sel_out == 4'hb ? 2'b01 : 2'b10))
        else $error("Wrong remote sensor selected.");
    a_sup_diode: assert property (conv_start_out && ch_sel_out < 4'hb |=> diode_sel_out == 2'b00)
        else $error("Remote sensor selected on a supply slot.");
    a_rem_excite: assert property (s_rem_start |=> !excite_high_out ##[1:7] excite_high_out)
        else $error("Excitation did not alternate in a remote step.");
    a_ch_range: assert property (busy_out |-> ch_sel_out <= 4'hc)
        else $error("Selector beyond the last channel.");
    a_warn_hold: assert property (!busy_out && !$past(busy_out) |-> $stable(sequencing_engine_warn_out))
        else $error("Warnings changed while idle.");
    a_start_busy: assert property (conv_start_out |-> busy_out)
        else $error("Conversion started while idle.");
endmodule // adcrr_monitor
bind adcrr_top adcrr_monitor #(.CONV_CYC(CONV_CYC), .RSUB_CYC(RSUB_CYC)) i_mon (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .sequencing_engine_adc_on_in(sequencing_engine_adc_on_in),
    .adc_data_in(adc_data_in), .ch_sel_out(ch_sel_out), .conv_start_out(conv_start_out),
    .diode_sel_out(diode_sel_out), .excite_high_out(excite_high_out),
    .sequencing_engine_warn_out(sequencing_engine_warn_out), .irq_out(irq_out), .busy_out(busy_out));

// ### bench/adcrr_afe_model.sv
// Analog front-end model: returns the code of the selected channel.
// Assumes codes_in holds twelve bits per channel, channel 0 lowest.
`timescale 1ns/1ps
module adcrr_afe_model (
    input  wire         clk_in,         // System clock.
    input  wire [155:0] codes_in,       // Code table per channel.
    input  wire [3:0]   ch_sel_in,      // Selected channel.
    input  wire         conv_start_in,  // Step start pulse.
    input  wire [1:0]   diode_sel_in,   // Remote sensor select.
    input  wire         excite_high_in, // Multiple current on.
    output wire [11:0]  adc_data_out    // Converted code.
);
    reg        saw_high = 1'b0; // Multiple current seen in this step.
    reg [11:0] noise = 12'h000; // Changing filler for a bad setup.
    wire [1:0] want_sel;        // Sensor pair the channel needs.
    wire       good;            // Remote setup was right.
    // A step only yields a difference if the multiple current was applied.
    always @(posedge clk_in) begin
        noise <= noise + 12'h5a3;
        if (conv_start_in) begin
            saw_high <= 1'b0;
        end else if (excite_high_in) begin
            saw_high <= 1'b1;
        end
    end
    assign want_sel = (ch_sel_in == 4'hb) ? 2'b01 : 2'b10;
    // A wrong sensor pair gives a code that moves every cycle.
    assign good = (ch_sel_in < 4'hb) || (saw_high && diode_sel_in == want_sel);
    assign adc_data_out = good ? codes_in[ch_sel_in * 12 +: 12] : noise;
endmodule // adcrr_afe_model

// ### bench/tb_top.sv
// Self-checking bench for the round-robin controller.
// Assumes the design and monitor compile beside it with the shared header.
`timescale 1ns/1ps
`include "adcrr_regs.vh"
module tb_top;
    reg          clk_in;   // 40 MHz clock.
    reg          rst_in;   // Reset, active high.
    reg  [7:0]   addr_in;  // Register address.
    reg  [15:0]  wdata_in; // Write data.
    reg          wr_in;    // Write strobe.
    reg          rd_in;    // Read strobe.
    reg          eng_in;   // Engine scan request.
    reg  [155:0] codes;    // Analog codes per channel.
    wire [15:0]  rdata_out;
    wire [11:0]  adc_data;
    wire [3:0]   ch_sel;
    wire [1:0]   dsel;
    wire [12:0]  warn;
    wire         start, excite, irq_out, busy_out;
    reg  [11:0]  res_e [0:12]; // Expected results.
    reg  [12:0]  warn_e;       // Expected warnings.
    reg  [12:0]  chen, dir;
    reg  [11:0]  v, lim;
    reg  [15:0]  got;
    int          err_count = 0, tests_run = 0, p, c;

    // Short slots keep the averaging pass within a few thousand cycles.
    adcrr_top #(.CONV_CYC(25'd8), .RSUB_CYC(25'd8)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sequencing_engine_adc_on_in(eng_in), .adc_data_in(adc_data), .ch_sel_out(ch_sel),
        .conv_start_out(start), .diode_sel_out(dsel), .excite_high_out(excite),
        .sequencing_engine_warn_out(warn), .irq_out(irq_out), .busy_out(busy_out));
    adcrr_afe_model i_afe (
        .clk_in(clk_in), .codes_in(codes), .ch_sel_in(ch_sel), .conv_start_in(start),
        .diode_sel_in(dsel), .excite_high_in(excite), .adc_data_out(adc_data));

    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rdchk(input [7:0] a, input [15:0] exp, input string nm);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
        chk(nm, got, exp);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Bounded wait; a hang shows up as a busy mismatch.
    task wait_idle;
        int n;
        n = 0;
        tick(3);
        while (busy_out !== 1'b0 && n < 20000) begin
            tick(1);
            n++;
        end
        chk("busy", {15'h0, busy_out}, 16'h0000);
    endtask
    // Temperature channels saturate at the offset-binary span ends.
    function [11:0] f_res(input int ch, input [11:0] x);
        if (ch >= 10 && x < `ADCRR_TEMP_MIN) f_res = `ADCRR_TEMP_MIN;
        else if (ch >= 10 && x > `ADCRR_TEMP_MAX) f_res = `ADCRR_TEMP_MAX;
        else f_res = x;
    endfunction
    task complete_run;
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (80000) @(posedge clk_in);
        err_count++;
        complete_run;
    end
    initial begin
        rst_in = 1'b1;
        addr_in = 8'h00;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        eng_in = 1'b0;
        codes = '0;
        warn_e = 13'h0000;
        for (c = 0; c < 13; c++) res_e[c] = 12'h000;
        void'($urandom(53310));
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        rdchk(`ADCRR_A_CTRL, 16'h0000, "ctrl");
        rdchk(`ADCRR_A_CHEN, 16'h0000, "chen");
        rdchk(`ADCRR_A_LIMDIR, 16'h1fff, "limdir");
        rdchk({`ADCRR_A_LIM_BASE, 4'hc}, 16'h0fff, "limit");
        rdchk(`ADCRR_A_IRQMSK, 16'h0000, "mask");
        rdchk(8'h7f, 16'h0000, "unmapped");
        wr(`ADCRR_A_WARN, 16'hffff);
        rdchk(`ADCRR_A_WARN, 16'h0000, "warn_ro");
        // Pass 0: all channels at code extremes; pass 3 averages.
        for (p = 0; p < 4; p++) begin
            chen = (p == 0) ? 13'h1fff : (13'($urandom) | 13'h0800);
            dir = 13'($urandom);
            for (c = 0; c < 13; c++) begin
                v = (p == 0) ? ((c % 2) ? 12'hfff : 12'h000) : 12'($urandom);
                lim = 12'($urandom);
                codes[c * 12 +: 12] <= v;
                wr({`ADCRR_A_LIM_BASE, c[3:0]}, {4'h0, lim});
                if (chen[c]) begin
                    res_e[c] = f_res(c, v);
                    warn_e[c] = dir[c] ? (res_e[c] > lim) : (res_e[c] < lim);
                end
            end
            wr(`ADCRR_A_CHEN, {3'h0, chen});
            wr(`ADCRR_A_LIMDIR, {3'h0, dir});
            wr(`ADCRR_A_IRQMSK, (p == 0) ? 16'h0000 : 16'h3fff);
            wr(`ADCRR_A_CTRL, (p == 3) ? 16'h0005 : 16'h0001);
            wait_idle;
            for (c = 0; c < 13; c++) rdchk({`ADCRR_A_RES_BASE, c[3:0]}, {4'h0, res_e[c]}, "result");
            chk("warn", {3'h0, warn}, {3'h0, warn_e});
            rdchk(`ADCRR_A_CTRL, (p == 3) ? 16'h0004 : 16'h0000, "run_clear");
            if (p == 0) begin
                chk("irq_masked", {15'h0, irq_out}, 16'h0000);
                wr(`ADCRR_A_IRQMSK, 16'h2000);
                tick(2);
            end
            chk("irq_set", {15'h0, irq_out}, 16'h0001);
            // Status holds the pass-done bit and one bit per enabled channel that warned.
            rdchk(`ADCRR_A_IRQST, {3'h1, warn_e & chen}, "status");
            chk("done_bit", {15'h0, got[13]}, 16'h0001);
            tick(2);
            chk("irq_clear", {15'h0, irq_out}, 16'h0000);
        end
        // Engine start with continuous set and run clear; the level alone keeps it looping.
        codes[12 +: 12] <= 12'h5a5;
        wr(`ADCRR_A_CHEN, 16'h0002);
        wr(`ADCRR_A_CTRL, 16'h0002);
        eng_in <= 1'b1;
        tick(100);
        chk("eng_busy", {15'h0, busy_out}, 16'h0001);
        eng_in <= 1'b0;
        wait_idle;
        rdchk({`ADCRR_A_RES_BASE, 4'h1}, 16'h05a5, "eng_result");
        // Continuous mode runs until the run bit is cleared.
        wr(`ADCRR_A_CTRL, 16'h0003);
        tick(100);
        chk("cont_busy", {15'h0, busy_out}, 16'h0001);
        wr(`ADCRR_A_CTRL, 16'h0000);
        wait_idle;
        complete_run;
    end
endmodule // tb_top
